// ### logic/rre_core.sv
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "rre_defines.svh"
module rre_core #(
  parameter int DEPTH = `RRE_STACK_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] file_rdata,
  output logic [6:0] file_addr,
  output logic [7:0] file_wdata,
  output logic file_we,
  output logic [`RRE_PCW-1:0] pc,
  output logic [7:0] working_reg,
  output logic carry,
  output logic global_irq_enable
);
  localparam int LW = $clog2(DEPTH + 1);

  rre_pkg::rre_core_t r_q;
  rre_pkg::rre_core_t r_d;
  rre_pkg::rre_op_t op;
  logic [7:0] rot;

  rre_stack_if #(.PCW(`RRE_PCW), .LW(LW)) stk ();

  rre_stack #(.PCW(`RRE_PCW), .DEPTH(DEPTH), .LW(LW)) u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .st(stk)
  );

  // instruction word to operation
  function automatic rre_pkg::rre_op_t decode(input logic [`RRE_IW-1:0] iw);
    if (iw == `RRE_OPC_RET_IRQ) begin
      return rre_pkg::RRE_OP_RET_IRQ;
    end else if (iw == `RRE_OPC_RETURN) begin
      return rre_pkg::RRE_OP_RETURN;
    end else if (iw[13:10] == `RRE_OPC_RET_LIT) begin
      return rre_pkg::RRE_OP_RET_LIT;
    end else if (iw[13:8] == `RRE_OPC_ROT_LEFT) begin
      return rre_pkg::RRE_OP_ROT_LEFT;
    end
    return rre_pkg::RRE_OP_OTHER;
  endfunction

  // offset recognised by the slave
  function automatic logic known(input logic [11:0] a);
    return a == `RRE_OFS_FETCH || a == `RRE_OFS_WREG || a == `RRE_OFS_STATUS ||
      a == `RRE_OFS_INTCTL || a == `RRE_OFS_PC || a == `RRE_OFS_STACK ||
      a == `RRE_OFS_DISCARD;
  endfunction

  assign op = decode(r_q.slot);
  // old carry in at bit 0, bit 7 leaves as new carry
  assign rot = {file_rdata[6:0], r_q.carry};

  always_comb begin
    r_d = r_q;
    r_d.file_we = 1'b0;
    stk.push = 1'b0;
    stk.pop = 1'b0;
    stk.push_data = pwdata[`RRE_PCW-1:0];

    // apb: one wait cycle, effect at the edge that sees pready high
    if (psel && penable && !r_q.pready) begin
      if (!(pwrite && paddr == `RRE_OFS_FETCH && r_q.slot_v)) begin
        r_d.pready = 1'b1;
        r_d.pslverr = !known(paddr);
        r_d.prdata = 32'h0000_0000;
        if (!pwrite) begin
          // read mux, unmapped offsets read zero
          case (paddr)
            `RRE_OFS_FETCH: begin
              r_d.prdata = {30'h0000_0000, r_q.state == rre_pkg::RRE_REFILL, r_q.slot_v};
            end
            `RRE_OFS_WREG: begin
              r_d.prdata = {24'h0000_00, r_q.w};
            end
            `RRE_OFS_STATUS: begin
              r_d.prdata = {31'h0000_0000, r_q.carry};
            end
            `RRE_OFS_INTCTL: begin
              r_d.prdata = {24'h0000_00, r_q.intctl};
            end
            `RRE_OFS_PC: begin
              r_d.prdata = {17'h0_0000, r_q.pc};
            end
            `RRE_OFS_STACK: begin
              r_d.prdata = {{(32-LW){1'b0}}, stk.level};
            end
            `RRE_OFS_DISCARD: begin
              r_d.prdata = {24'h0000_00, r_q.discards};
            end
            default: begin
              r_d.prdata = 32'h0000_0000;
            end
          endcase
        end
      end
    end else if (psel && penable && r_q.pready) begin
      r_d.pready = 1'b0;
      r_d.pslverr = 1'b0;
      if (pwrite && !r_q.pslverr) begin
        // write side, lands at the edge that sees pready high
        case (paddr)
          `RRE_OFS_FETCH: begin
            r_d.slot = pwdata[`RRE_IW-1:0];
            r_d.slot_v = 1'b1;
            r_d.file_addr = pwdata[6:0];
          end
          `RRE_OFS_WREG: begin
            r_d.w = pwdata[7:0];
          end
          `RRE_OFS_STATUS: begin
            r_d.carry = pwdata[`RRE_CARRY_BIT];
          end
          `RRE_OFS_INTCTL: begin
            r_d.intctl = pwdata[7:0];
          end
          `RRE_OFS_PC: begin
            r_d.pc = pwdata[`RRE_PCW-1:0];
          end
          `RRE_OFS_STACK: begin
            stk.push = 1'b1;
          end
          default: begin
            r_d.w = r_q.w;
          end
        endcase
      end
    end else begin
      r_d.pready = 1'b0;
      r_d.pslverr = 1'b0;
    end

    // execution, wins over a software write in the same cycle, except a stack push, which rre_stack takes in place of the pop
    case (r_q.state)
      rre_pkg::RRE_RUN: begin
        if (r_q.slot_v) begin
          r_d.slot_v = 1'b0;
          case (op)
            // returns pop the stack and go through one refill cycle
            rre_pkg::RRE_OP_RET_IRQ: begin
              stk.pop = 1'b1;
              r_d.pc = stk.top;
              r_d.intctl[`RRE_IRQ_EN_BIT] = 1'b1;
              r_d.state = rre_pkg::RRE_REFILL;
            end

            rre_pkg::RRE_OP_RETURN: begin
              stk.pop = 1'b1;
              r_d.pc = stk.top;
              r_d.state = rre_pkg::RRE_REFILL;
            end

            rre_pkg::RRE_OP_RET_LIT: begin
              r_d.w = r_q.slot[7:0];
              stk.pop = 1'b1;
              r_d.pc = stk.top;
              r_d.state = rre_pkg::RRE_REFILL;
            end

            // rotate through carry, done in this one cycle
            rre_pkg::RRE_OP_ROT_LEFT: begin
              r_d.carry = file_rdata[7];
              if (r_q.slot[`RRE_DEST_BIT]) begin
                r_d.file_wdata = rot;
                r_d.file_we = 1'b1;
              end else begin
                r_d.w = rot;
              end
              r_d.pc = r_q.pc + `RRE_PCW'(1);
            end

            // anything else only advances the program counter
            default: r_d.pc = r_q.pc + `RRE_PCW'(1);
          endcase
        end
      end
      rre_pkg::RRE_REFILL: begin
        // second cycle: drop whatever was fetched behind the return
        if (r_q.slot_v) begin
          r_d.slot_v = 1'b0;
          r_d.discards = r_q.discards + 8'h01;
        end
        r_d.state = rre_pkg::RRE_RUN;
      end
      default: r_d.state = rre_pkg::RRE_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
      r_q.state <= rre_pkg::RRE_RUN;
      r_q.pc <= `RRE_RST_PC;
      r_q.w <= `RRE_RST_W;
      r_q.intctl <= `RRE_RST_INTCTL;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from the state register
  assign prdata = r_q.prdata;
  assign pready = r_q.pready;
  assign pslverr = r_q.pslverr;
  assign file_addr = r_q.file_addr;
  assign file_wdata = r_q.file_wdata;
  assign file_we = r_q.file_we;
  assign pc = r_q.pc;
  assign working_reg = r_q.w;
  assign carry = r_q.carry;
  assign global_irq_enable = r_q.intctl[`RRE_IRQ_EN_BIT];
endmodule // rre_core

// ### logic/rre_defines.svh
`ifndef RRE_DEFINES_SVH
`define RRE_DEFINES_SVH

// widths
`define RRE_IW 14
`define RRE_PCW 15
`define RRE_STACK_DEPTH 16

// apb byte offsets
`define RRE_OFS_FETCH 12'h000
`define RRE_OFS_WREG 12'h004
`define RRE_OFS_STATUS 12'h008
`define RRE_OFS_INTCTL 12'h00C
`define RRE_OFS_PC 12'h010
`define RRE_OFS_STACK 12'h014
`define RRE_OFS_DISCARD 12'h018

// field positions
`define RRE_IRQ_EN_BIT 7
`define RRE_CARRY_BIT 0
`define RRE_DEST_BIT 7

// opcode encodings; literal return matched on bits 13:10, rotate on 13:8
`define RRE_OPC_RET_IRQ 14'h0009
`define RRE_OPC_RETURN 14'h0008
`define RRE_OPC_RET_LIT 4'hD
`define RRE_OPC_ROT_LEFT 6'h0D

// reset values
`define RRE_RST_PC 15'h0000
`define RRE_RST_W 8'h00
`define RRE_RST_INTCTL 8'h00

`endif

// ### logic/rre_pkg.sv
`include "rre_defines.svh"
package rre_pkg;

  // core sequencing, gray along run -> refill
  typedef enum logic [1:0] {
    RRE_RUN = 2'b00,
    RRE_REFILL = 2'b01
  } rre_state_t;

  typedef enum logic [2:0] {
    RRE_OP_OTHER,
    RRE_OP_RET_IRQ,
    RRE_OP_RETURN,
    RRE_OP_RET_LIT,
    RRE_OP_ROT_LEFT
  } rre_op_t;

  // whole state of the executing core apart from the return stack, which rre_stack holds
  typedef struct packed {
    rre_state_t state;
    logic [`RRE_IW-1:0] slot;
    logic slot_v;
    logic [`RRE_PCW-1:0] pc;
    logic [7:0] w;
    logic carry;
    logic [7:0] intctl;
    logic [6:0] file_addr;
    logic [7:0] file_wdata;
    logic file_we;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] discards;
  } rre_core_t;

endpackage

// ### logic/rre_stack.sv
`timescale 1ns/1ps
module rre_stack #(
  parameter int PCW = 15,
  parameter int DEPTH = 16,
  parameter int LW = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  rre_stack_if.mem st
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][PCW-1:0] mem;
    logic [PW-1:0] ptr;
    logic [LW-1:0] level;
    logic [PCW-1:0] top;
  } rre_stk_t;

  rre_stk_t r_q;
  rre_stk_t r_d;

  // circular stack, top held in a register
  always_comb begin
    r_d = r_q;
    if (st.push) begin
      r_d.mem[r_q.ptr] = st.push_data;
      r_d.ptr = r_q.ptr + PW'(1);
      r_d.top = st.push_data;
      if (r_q.level != LW'(DEPTH)) begin
        r_d.level = r_q.level + LW'(1);
      end
    end else if (st.pop) begin
      r_d.ptr = r_q.ptr - PW'(1);
      r_d.top = r_q.mem[r_q.ptr - PW'(2)];
      if (r_q.level != '0) begin
        r_d.level = r_q.level - LW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign st.top = r_q.top;
  assign st.level = r_q.level;
endmodule // rre_stack

// ### logic/rre_stack_if.sv
`timescale 1ns/1ps
interface rre_stack_if #(
  parameter int PCW = 15,
  parameter int LW = 5
);
  logic push;
  logic pop;
  logic [PCW-1:0] push_data;
  logic [PCW-1:0] top;
  logic [LW-1:0] level;

  modport core (output push, output pop, output push_data, input top, input level);
  modport mem (input push, input pop, input push_data, output top, output level);
endinterface

// ### verif/rre_core_monitor.sv
`timescale 1ns/1ps
`include "rre_defines.svh"
module rre_core_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] file_rdata,
  input wire logic [6:0] file_addr,
  input wire logic [7:0] file_wdata,
  input wire logic file_we,
  input wire logic [7:0] working_reg,
  input wire logic carry,
  input wire logic global_irq_enable
);
  logic hit;
  logic f_wr;
  logic rot_wr;
  // accepted writes, fetches and rotate fetches
  assign hit = psel && penable && pready && pwrite;
  assign f_wr = hit && (paddr == `RRE_OFS_FETCH);
  assign rot_wr = f_wr && (pwdata[13:8] == 6'h0D);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_bound: assert property (psel && penable && !pready |-> ##[1:4] pready)
    else $error("no ready in time");
  a_rot_result: assert property (file_we |-> file_wdata == {$past(file_rdata[6:0]),
    $past(carry)} && carry == $past(file_rdata[7])) else $error("bad rotate result");
  a_we_single: assert property (file_we |=> !file_we)
    else $error("file write longer than one cycle");
  a_dest_wreg: assert property (rot_wr && !pwdata[7] |-> ##2 !file_we &&
    working_reg == {$past(file_rdata[6:0]), $past(carry)}) else $error("bad w rotate");
  a_dest_file: assert property (rot_wr && pwdata[7] |-> ##2 file_we &&
    file_addr == $past(pwdata[6:0], 2)) else $error("missing file write");
  a_carry_cause: assert property ($changed(carry) |->
    $past(hit && paddr == `RRE_OFS_STATUS) || $past(rot_wr, 2)) else $error("stray carry");
  a_irq_enable: assert property (f_wr && pwdata[13:0] == 14'h0009 |-> ##2
    global_irq_enable) else $error("irq enable not set");
  a_w_cause: assert property ($changed(working_reg) |->
    $past(hit && paddr == `RRE_OFS_WREG) || $past(f_wr, 2)) else $error("stray w change");
  c_file_write: cover property (file_we);
  c_irq_ret: cover property (f_wr && pwdata[13:0] == 14'h0009);
  c_bus_error: cover property (pready && pslverr);
endmodule // rre_core_monitor
bind rre_core rre_core_monitor u_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .file_rdata(file_rdata), .file_addr(file_addr), .file_wdata(file_wdata),
  .file_we(file_we), .working_reg(working_reg), .carry(carry),
  .global_irq_enable(global_irq_enable));

// ### verif/tb_return_and_rotate_exec.sv
`timescale 1ns/1ps
`include "rre_defines.svh"
module tb_return_and_rotate_exec;
  typedef struct packed {logic [13:0] ins; logic [7:0] fv; logic ci; logic [7:0] res;
    logic co;} rre_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic [7:0] file_rdata = 8'h00, file_wdata, working_reg, last_wd;
  logic [6:0] file_addr;
  logic [14:0] pc;
  logic file_we, carry, irq_en;
  int fail_count = 0, comparisons = 0, we_cnt = 0, we0;
  // rotate cases: instruction, file value, carry in, result, carry out
  rre_row_t rows [4] = '{'{14'h0D05, 8'hE6, 1'b0, 8'hCC, 1'b1},
    '{14'h0D85, 8'hE6, 1'b0, 8'hCC, 1'b1}, '{14'h0D7F, 8'h01, 1'b1, 8'h03, 1'b0},
    '{14'h0DFF, 8'h80, 1'b1, 8'h01, 1'b1}};
  rre_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .file_rdata(file_rdata), .file_addr(file_addr),
    .file_wdata(file_wdata), .file_we(file_we), .pc(pc), .working_reg(working_reg),
    .carry(carry), .global_irq_enable(irq_en));
  // clock
  initial begin
    forever #50 pclk = ~pclk;
  end
  // file write capture
  always @(posedge pclk) begin
    if (file_we === 1'b1) begin
      we_cnt <= we_cnt + 1;
      last_wd <= file_wdata;
    end
  end
  task automatic print_verdict();
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      $display("unexpected at %0t got %h expected %h", $time, g, e);
      fail_count++;
    end
  endtask
  // one apb transfer, waits for ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // watchdog
  initial begin
    #500_000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk({6'h00, pc, working_reg, carry, irq_en, file_we}, 32'h0000_0000);
    foreach (rows[i]) begin
      apb(1, `RRE_OFS_STATUS, {31'h0000_0000, rows[i].ci});
      apb(1, `RRE_OFS_WREG, 32'h0000_005A);
      file_rdata <= rows[i].fv;
      we0 = we_cnt;
      apb(1, `RRE_OFS_FETCH, {18'h0_0000, rows[i].ins});
      apb(0, `RRE_OFS_WREG, 32'h0000_0000);
      chk(r, rows[i].ins[7] ? 32'h0000_005A : {24'h00_0000, rows[i].res});
      chk({31'h0000_0000, carry}, {31'h0000_0000, rows[i].co});
      chk({25'h000_0000, file_addr}, {25'h000_0000, rows[i].ins[6:0]});
      chk(32'(we_cnt - we0), {31'h0000_0000, rows[i].ins[7]});
      if (rows[i].ins[7]) chk({24'h00_0000, last_wd}, {24'h00_0000, rows[i].res});
    end
    // returns: stack holds three addresses, carry set beforehand
    apb(1, `RRE_OFS_STATUS, 32'h0000_0001);
    apb(1, `RRE_OFS_STACK, 32'h0000_1234);
    apb(1, `RRE_OFS_STACK, 32'h0000_0456);
    apb(1, `RRE_OFS_STACK, 32'h0000_7FFF);
    apb(1, `RRE_OFS_FETCH, 32'h0000_34FF);
    apb(0, `RRE_OFS_WREG, 32'h0000_0000);
    chk(r, 32'h0000_00FF);
    chk({17'h0_0000, pc}, 32'h0000_7FFF);
    apb(0, `RRE_OFS_STACK, 32'h0000_0000);
    chk(r, 32'h0000_0002);
    apb(1, `RRE_OFS_FETCH, 32'h0000_0008);
    apb(0, `RRE_OFS_STACK, 32'h0000_0000);
    chk(r, 32'h0000_0001);
    chk({15'h0000, pc, carry, irq_en}, {15'h0000, 15'h0456, 2'h2});
    apb(1, `RRE_OFS_FETCH, 32'h0000_0009);
    apb(0, `RRE_OFS_INTCTL, 32'h0000_0000);
    chk(r, 32'h0000_0080);
    chk({15'h0000, pc, carry, irq_en}, {15'h0000, 15'h1234, 2'h3});
    apb(1, `RRE_OFS_FETCH, 32'h0000_0000);
    apb(0, `RRE_OFS_DISCARD, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    chk({17'h0_0000, pc}, 32'h0000_1235);
    apb(0, 12'h01C, 32'h0000_0000);
    chk({r[30:0], err}, 32'h0000_0001);
    // mid-run reset clears the core and empties the stack
    apb(1, `RRE_OFS_STACK, 32'h0000_0111);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk({6'h00, pc, working_reg, carry, irq_en, file_we}, 32'h0000_0000);
    apb(0, `RRE_OFS_STACK, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    print_verdict();
  end
endmodule // tb_return_and_rotate_exec
